// ### hw/bdm_pkg.sv
package bdm_pkg;

  // ****************************************
  // address space
  // ****************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned OFS_W = 8;
  localparam int unsigned BANK_COUNT = 16;
  localparam int unsigned BANK_SIZE = 256;
  localparam int unsigned SPACE_SIZE = 4096;

  // ****************************************
  // implemented regions
  // ****************************************
  // gpr banks 0..1 implemented, usb dual-access ram in bank 2
  localparam logic [3:0] GPR_LAST_BANK = 4'h1;
  localparam logic [3:0] USB_BANK = 4'h2;
  localparam int unsigned RAM_BANKS = 3;
  localparam int unsigned RAM_SIZE = RAM_BANKS * BANK_SIZE;
  localparam logic [11:0] SFR_BASE = 12'hF60;
  localparam logic [11:0] SFR_TOP = 12'hFFF;
  localparam logic [11:0] BANK_PTR_ADDR = 12'hFE0;
  localparam logic [3:0] SFR_BANK = 4'hF;

  // ****************************************
  // access bank split
  // ****************************************
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] BANK_PTR_RESET = 4'h0;
  localparam logic [1:0] PHASE_RESET = 2'h0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    BDM_Q1 = 2'b00,
    BDM_Q2 = 2'b01,
    BDM_Q3 = 2'b10,
    BDM_Q4 = 2'b11
  } bdm_phase_e;

  typedef enum logic [1:0] {
    BDM_OP_NONE = 2'b00,
    BDM_OP_BANKED = 2'b01,
    BDM_OP_FULL = 2'b10,
    BDM_OP_LOADBANK = 2'b11
  } bdm_op_e;

  // core request, held stable for one instruction cycle
  typedef struct packed {
    bdm_op_e op;
    logic access_sel;
    logic [7:0] offset;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic wr_en;
    logic [7:0] wr_data;
    logic [3:0] literal;
  } bdm_core_req_s;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
  } bdm_usb_req_s;

endpackage : bdm_pkg

// ### hw/bdm_banked_data_memory.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: twelve-bit addresses, up to 4096 bytes
// RULE2: sixteen banks of 256 bytes each
// RULE3: unimplemented locations read as zero
// RULE4: dual ram is plain gpr when usb off
// RULE5: usb on: core and engine share ram
// RULE6: bank pointer four bits, upper read zero
// RULE7: banked address is pointer plus offset
// RULE8: load-bank instruction loads pointer from literal
// RULE9: unimplemented banks drop writes, read zero
// RULE10: status flags update as if access succeeded
// RULE11: full-address move ignores bank pointer
// RULE12: other instructions use pointer or access bank
// RULE13: access bank joins bank0 low, bank15 high
// RULE14: access bit one uses bank pointer
// RULE15: access bit zero forces access bank
// RULE16: forced access completes in one cycle
// RULE17: standard access map only without extended isa; code ignores extended_isa_enable_in and always uses the standard map
// RULE18: gprs start at 000h ascending upward
// RULE19: gpr contents not reset
// RULE20: special registers occupy F60h to FFFh
// RULE21: operand read q2, destination write q4
// RULE22: same-location core/usb access arbitrated deterministically
module bdm_banked_data_memory
  import bdm_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // configuration and sfr side
  input wire logic usb_enable_in,
  input wire logic extended_isa_enable_in,
  input wire logic [7:0] sfr_rd_data_in,
  // core request
  input wire bdm_core_req_s core_req_in,
  // usb serial engine request
  input wire bdm_usb_req_s usb_req_in,
  // core answer
  output logic [7:0] core_rd_data_out,
  output logic core_rd_valid_out,
  output logic [1:0] phase_out,
  output logic [3:0] bank_pointer_out,
  output logic [11:0] core_addr_out,
  output logic core_wr_done_out,
  output logic sfr_wr_out,
  output logic [7:0] sfr_wr_data_out,
  output logic [11:0] sfr_addr_out,
  // usb answer
  output logic [7:0] usb_rd_data_out,
  output logic usb_wr_lost_out
);

  // ****************************************
  // state
  // ****************************************
  bdm_phase_e phase;
  logic [3:0] bank_pointer;
  logic [7:0] ram [RAM_SIZE];
  logic [7:0] core_rd_data;
  logic core_rd_valid;
  logic core_wr_done;
  logic sfr_wr;
  logic [7:0] usb_rd_data;
  logic usb_wr_lost;
  logic [7:0] operand;
  bdm_phase_e next_phase;

  // ****************************************
  // address formation
  // ****************************************
  wire logic [11:0] banked_addr;
  wire logic [11:0] access_addr;
  wire logic [11:0] low_addr;
  wire logic [11:0] src_addr;
  wire logic [11:0] dst_addr;
  wire logic is_full;

  // RULE7: pointer concatenated with offset
  assign banked_addr = {bank_pointer, core_req_in.offset};
  // RULE13: below split bank 0, else bank 15
  // RULE17: extended isa mapping not covered, standard map kept
  assign access_addr = (core_req_in.offset < ACCESS_SPLIT) ?
                       {ACCESS_LOW_BANK, core_req_in.offset} :
                       {SFR_BANK, core_req_in.offset};
  // RULE14: access bit one selects banked
  // RULE15: access bit zero ignores pointer
  // RULE12: short operand resolves one of two ways
  assign low_addr = core_req_in.access_sel ? banked_addr : access_addr;
  assign is_full = (core_req_in.op == BDM_OP_FULL);
  // RULE11: full move takes both addresses verbatim
  assign src_addr = is_full ? core_req_in.src_addr : low_addr;
  assign dst_addr = is_full ? core_req_in.dst_addr : low_addr;

  // ****************************************
  // region decode
  // ****************************************
  wire logic src_ram;
  wire logic dst_ram;
  wire logic src_sfr;
  wire logic dst_sfr;
  wire logic src_bp;
  wire logic dst_bp;
  wire logic dst_usb;
  wire logic [9:0] src_idx;
  wire logic [9:0] dst_idx;
  wire logic [9:0] usb_idx;
  wire logic core_wr_now;
  wire logic usb_wr_ok;
  wire logic usb_wins_clash;

  // RULE18: gprs from 000h upward
  // RULE2: bank index picks region
  // RULE4: usb bank acts as gpr when usb off
  assign src_ram = (src_addr[11:8] <= USB_BANK);
  assign dst_ram = (dst_addr[11:8] <= USB_BANK);
  // RULE20: special registers at F60h..FFFh
  assign src_sfr = (src_addr >= SFR_BASE);
  assign dst_sfr = (dst_addr >= SFR_BASE);
  assign src_bp = (src_addr == BANK_PTR_ADDR);
  assign dst_bp = (dst_addr == BANK_PTR_ADDR);
  assign dst_usb = (dst_addr[11:8] == USB_BANK);
  assign src_idx = src_addr[9:0];
  assign dst_idx = dst_addr[9:0];
  assign usb_idx = {USB_BANK[1:0], usb_req_in.addr};
  assign core_wr_now = (phase == BDM_Q4) && core_req_in.wr_en &&
                       (core_req_in.op != BDM_OP_NONE) &&
                       (core_req_in.op != BDM_OP_LOADBANK);
  // RULE22: core write wins on same byte in q4
  assign usb_wins_clash = core_wr_now && dst_ram && dst_usb && (dst_idx == usb_idx);
  // RULE5: engine writes only while usb enabled
  assign usb_wr_ok = usb_enable_in && usb_req_in.wr_en && !usb_wins_clash;

  // ****************************************
  // phase sequencer
  // ****************************************
  always_comb begin
    case (phase)
      BDM_Q1: next_phase = BDM_Q2;
      BDM_Q2: next_phase = BDM_Q3;
      BDM_Q3: next_phase = BDM_Q4;
      BDM_Q4: next_phase = BDM_Q1;
      default: next_phase = BDM_Q1;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase <= BDM_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // ****************************************
  // operand read
  // ****************************************
  wire logic [7:0] read_mux;

  // RULE3: holes read as zero
  // RULE9: unimplemented bank reads zero
  // RULE6: upper pointer bits read zero
  assign read_mux = src_bp ? {4'h0, bank_pointer} :
                    src_sfr ? sfr_rd_data_in :
                    src_ram ? ram[src_idx] : 8'h00;

  // RULE21: operand sampled in q2
  // RULE16: one instruction cycle, no pointer update first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      operand <= 8'h00;
      core_rd_data <= 8'h00;
      core_rd_valid <= 1'b0;
    end else begin
      core_rd_valid <= (phase == BDM_Q2) && (core_req_in.op != BDM_OP_NONE);
      if (phase == BDM_Q2) begin
        operand <= read_mux;
        core_rd_data <= read_mux;
      end
    end
  end

  // ****************************************
  // bank pointer
  // ****************************************
  // RULE8: literal load; RULE6: four bits kept
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bank_pointer <= BANK_PTR_RESET;
    end else if (phase == BDM_Q4 && core_req_in.op == BDM_OP_LOADBANK) begin
      bank_pointer <= core_req_in.literal;
    end else if (core_wr_now && dst_bp) begin
      bank_pointer <= core_req_in.wr_data[3:0];
    end
  end

  // ****************************************
  // data ram
  // ****************************************
  // no reset on storage: contents survive every reset
  // RULE19: ram left uninitialised
  // RULE1: 12-bit space, ram indexed by low bits
  // RULE9: writes outside ram banks dropped
  // full move writes the q2 operand, others the core data
  wire logic [7:0] wr_value;
  assign wr_value = is_full ? operand : core_req_in.wr_data;

  always_ff @(posedge clk_in) begin
    if (core_wr_now && dst_ram) begin
      ram[dst_idx] <= wr_value;
    end
    if (usb_wr_ok) begin
      ram[usb_idx] <= usb_req_in.wr_data;
    end
  end

  // ****************************************
  // core and usb answers
  // ****************************************
  // RULE10: done pulses for every write, mapped or not
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_wr_done <= 1'b0;
      sfr_wr <= 1'b0;
      sfr_wr_data_out <= 8'h00;
      sfr_addr_out <= 12'h000;
      core_addr_out <= 12'h000;
      usb_rd_data <= 8'h00;
      usb_wr_lost <= 1'b0;
    end else begin
      core_wr_done <= core_wr_now;
      sfr_wr <= core_wr_now && dst_sfr && !dst_bp;
      sfr_wr_data_out <= wr_value;
      sfr_addr_out <= (phase == BDM_Q4) ? dst_addr : src_addr;
      core_addr_out <= (phase == BDM_Q4) ? dst_addr : src_addr;
      // RULE5: engine reads shared bank when enabled
      usb_rd_data <= (usb_enable_in && usb_req_in.rd_en) ? ram[usb_idx] : 8'h00;
      usb_wr_lost <= usb_enable_in && usb_req_in.wr_en && usb_wins_clash;
    end
  end

  assign core_rd_data_out = core_rd_data;
  assign core_rd_valid_out = core_rd_valid;
  assign phase_out = phase;
  assign bank_pointer_out = bank_pointer;
  assign core_wr_done_out = core_wr_done;
  assign sfr_wr_out = sfr_wr;
  assign usb_rd_data_out = usb_rd_data;
  assign usb_wr_lost_out = usb_wr_lost;

endmodule : bdm_banked_data_memory

// ### verification/bdm_chk.sv
`timescale 1ns/1ps
module bdm_chk
  import bdm_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // requests
  input wire logic usb_enable_in,
  input wire bdm_core_req_s core_req_in,
  input wire bdm_usb_req_s usb_req_in,
  // answers
  input wire logic core_rd_valid_out,
  input wire logic [1:0] phase_out,
  input wire logic [3:0] bank_pointer_out,
  input wire logic [11:0] core_addr_out,
  input wire logic core_wr_done_out,
  input wire logic sfr_wr_out,
  input wire logic [11:0] sfr_addr_out,
  input wire logic [7:0] usb_rd_data_out
);
  // ****
  // properties
  // ****
  default clocking dcb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire logic q2 = (phase_out == BDM_Q2);
  wire logic q4 = (phase_out == BDM_Q4);
  wire logic bnk = (core_req_in.op == BDM_OP_BANKED);
  wire logic full = (core_req_in.op == BDM_OP_FULL);
  wire logic acc = core_req_in.access_sel;
  wire logic [7:0] ofs = core_req_in.offset;
  wire logic [3:0] lit = core_req_in.literal;
  a_phase_wrap: assert property (q4 |=> phase_out == BDM_Q1)
    else $error("phase did not wrap");
  a_valid_after_q2: assert property (core_rd_valid_out |-> $past(phase_out) == BDM_Q2)
    else $error("read valid outside q2");
  a_done_after_q4: assert property (core_wr_done_out |-> $past(phase_out) == BDM_Q4)
    else $error("write done outside q4");
  a_load_bank_lit: assert property (q4 && core_req_in.op == BDM_OP_LOADBANK
    |=> bank_pointer_out == $past(lit))
    else $error("bank pointer not loaded");
  a_banked_addr: assert property (q2 && bnk && acc
    |=> core_addr_out == {$past(bank_pointer_out), $past(ofs)})
    else $error("banked address wrong");
  a_access_map: assert property (q2 && bnk && !acc |=> core_addr_out ==
    {(($past(ofs) < ACCESS_SPLIT) ? ACCESS_LOW_BANK : SFR_BANK), $past(ofs)})
    else $error("access bank address wrong");
  a_full_src: assert property (q2 && full |=> core_addr_out == $past(core_req_in.src_addr))
    else $error("move source wrong");
  a_full_dst: assert property (q4 && full |=> core_addr_out == $past(core_req_in.dst_addr))
    else $error("move target wrong");
  a_usb_off_zero: assert property (!usb_enable_in && usb_req_in.rd_en
    |=> usb_rd_data_out == 8'h00)
    else $error("engine read while off");
  a_sfr_wr_range: assert property (sfr_wr_out |-> sfr_addr_out >= SFR_BASE)
    else $error("sfr write below base");
  c_full: cover property (q4 && full);
  c_access: cover property (q2 && bnk && !acc);
  c_usb_wr: cover property (usb_enable_in && usb_req_in.wr_en);
  c_clash: cover property (usb_enable_in && usb_req_in.wr_en && q4 && core_req_in.wr_en);
endmodule : bdm_chk

bind bdm_banked_data_memory bdm_chk i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .usb_enable_in(usb_enable_in), .core_req_in(core_req_in), .usb_req_in(usb_req_in),
  .core_rd_valid_out(core_rd_valid_out), .phase_out(phase_out),
  .bank_pointer_out(bank_pointer_out), .core_addr_out(core_addr_out),
  .core_wr_done_out(core_wr_done_out), .sfr_wr_out(sfr_wr_out),
  .sfr_addr_out(sfr_addr_out), .usb_rd_data_out(usb_rd_data_out));

// ### verification/bdm_usb_model.sv
`timescale 1ns/1ps
module bdm_usb_model
  import bdm_pkg::*;
(
  // engine side
  input wire logic clk_in,
  input wire logic [7:0] usb_rd_data_in,
  output bdm_usb_req_s usb_req_out
);
  initial usb_req_out = '0;
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge clk_in);
    usb_req_out = '{wr_en: wr, rd_en: !wr, addr: a, wr_data: d};
    @(negedge clk_in);
    q = usb_rd_data_in;
    // released lines show inverse, never a stale copy
    usb_req_out = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wr_data: ~d};
  endtask : xfer
endmodule : bdm_usb_model

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bdm_pkg::*;
  logic clk_in, rst_n_in, usb_en, done;
  logic lost, swr;
  logic [7:0] swd;
  logic [11:0] sad;
  bdm_core_req_s req;
  bdm_usb_req_s ureq;
  logic [7:0] rd, urd, q;
  logic [3:0] bp;
  logic [1:0] ph;
  int miscompares, compares;
  bdm_banked_data_memory i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .usb_enable_in(usb_en), .extended_isa_enable_in(1'b0), .sfr_rd_data_in(8'hC3),
    .core_req_in(req), .usb_req_in(ureq), .core_rd_data_out(rd),
    .core_rd_valid_out(), .phase_out(ph), .bank_pointer_out(bp), .core_addr_out(),
    .core_wr_done_out(done), .sfr_wr_out(swr), .sfr_wr_data_out(swd), .sfr_addr_out(sad),
    .usb_rd_data_out(urd), .usb_wr_lost_out(lost));
  bdm_usb_model i_usb (.clk_in(clk_in), .usb_rd_data_in(urd), .usb_req_out(ureq));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // ****
  // shared tasks
  // ****
  task chk(input string n, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // one whole instruction, held from q1 to q4
  task op(input bdm_op_e o, input logic a, input logic [7:0] f, input logic [11:0] s,
      input logic [11:0] d, input logic we, input logic [7:0] wd, input logic [3:0] l);
    int n;
    n = 0;
    while (ph !== BDM_Q1) begin
      @(negedge clk_in);
      n++;
      if (n > 8) begin
        miscompares++;
        end_sim();
      end
    end
    req = '{o, a, f, s, d, we, wd, l};
    repeat (4) @(negedge clk_in);
  endtask : op
  task bk(input logic a, input logic [7:0] f, input logic we, input logic [7:0] d);
    op(BDM_OP_BANKED, a, f, 12'h000, 12'h000, we, d, 4'h0);
  endtask : bk
  task lb(input logic [3:0] l);
    op(BDM_OP_LOADBANK, 1'b0, 8'h00, 12'h000, 12'h000, 1'b0, 8'h00, l);
  endtask : lb
  // ****
  // scenarios
  // ****
  task t_bank;
    lb(4'h1);
    chk("bank", 12'h001, bp);
    bk(1'b1, 8'h34, 1'b1, 8'hA5);
    bk(1'b1, 8'h34, 1'b0, 8'h00);
    chk("rd134", 12'h0A5, rd);
    lb(4'h5);
    bk(1'b1, 8'h34, 1'b1, 8'h77);
    chk("done", 12'h001, done);
    bk(1'b1, 8'h34, 1'b0, 8'h00);
    chk("rd534", 12'h000, rd);
    lb(4'h1);
    bk(1'b1, 8'h34, 1'b0, 8'h00);
    chk("keep", 12'h0A5, rd);
  endtask : t_bank
  task t_access;
    bk(1'b0, 8'h10, 1'b1, 8'h5C);
    lb(4'h0);
    bk(1'b1, 8'h10, 1'b0, 8'h00);
    chk("acc_lo", 12'h05C, rd);
    bk(1'b0, 8'h70, 1'b0, 8'h00);
    chk("acc_hi", 12'h0C3, rd);
    bk(1'b0, 8'h70, 1'b1, 8'h3C);
    chk("sfr_wr", 12'h001, swr);
    chk("sfr_data", 12'h03C, swd);
    chk("sfr_addr", 12'hF70, sad);
    bk(1'b0, 8'hE0, 1'b1, 8'hF7);
    chk("bp_wr", 12'h007, bp);
    chk("bp_no_sfr", 12'h000, swr);
    bk(1'b0, 8'hE0, 1'b0, 8'h00);
    chk("bp_rd", 12'h007, rd);
  endtask : t_access
  task t_move;
    lb(4'h3);
    op(BDM_OP_FULL, 1'b0, 8'h00, 12'h010, 12'h1F0, 1'b1, 8'h00, 4'h0);
    lb(4'h1);
    bk(1'b1, 8'hF0, 1'b0, 8'h00);
    chk("move", 12'h05C, rd);
  endtask : t_move
  task t_usb;
    lb(4'h2);
    bk(1'b1, 8'h07, 1'b1, 8'h81);
    bk(1'b1, 8'h07, 1'b0, 8'h00);
    chk("gpr2", 12'h081, rd);
    i_usb.xfer(1'b0, 8'h07, 8'h00, q);
    chk("usb_off", 12'h000, q);
    usb_en = 1'b1;
    i_usb.xfer(1'b1, 8'h08, 8'h5A, q);
    bk(1'b1, 8'h08, 1'b0, 8'h00);
    chk("usb_wr", 12'h05A, rd);
    i_usb.xfer(1'b0, 8'h07, 8'h00, q);
    chk("usb_rd", 12'h081, q);
    lb(4'h2);
    // engine write lands on the core's q4 edge, same byte
    fork
      bk(1'b1, 8'h09, 1'b1, 8'h11);
      begin
        repeat (2) @(negedge clk_in);
        i_usb.xfer(1'b1, 8'h09, 8'hEE, q);
      end
    join
    chk("usb_lost", 12'h001, lost);
    bk(1'b1, 8'h09, 1'b0, 8'h00);
    chk("clash", 12'h011, rd);
  endtask : t_usb
  task t_reset;
    bk(1'b0, 8'h20, 1'b1, 8'h96);
    lb(4'h9);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("rst_bp", 12'h000, bp);
    chk("rst_rd", 12'h000, rd);
    rst_n_in = 1'b1;
    bk(1'b0, 8'h20, 1'b0, 8'h00);
    chk("rst_keep", 12'h096, rd);
  endtask : t_reset
  initial begin
    rst_n_in = 1'b0;
    usb_en = 1'b0;
    req = '0;
    miscompares = 0;
    compares = 0;
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_bank();
    t_access();
    t_move();
    t_usb();
    t_reset();
    end_sim();
  end
endmodule : testbench
